//--- wdt_consts.svh
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH
`define OFF_START_TASK      12'h000
`define OFF_START_LINK      12'h080
`define OFF_TIMEOUT_FLAG    12'h100
`define OFF_TIMEOUT_LINK    12'h180
`define OFF_IRQ_EN_SET      12'h304
`define OFF_IRQ_EN_CLR      12'h308
`define OFF_IRQ_STATUS      12'h30C
`define OFF_RUN_STATE       12'h400
`define OFF_REQ_STATE       12'h404
`define OFF_RELOAD_VALUE    12'h504
`define OFF_RELOAD_REGISTER_ENABLES            12'h508
`define OFF_PAUSE_CFG       12'h50C
`define OFF_RR_BASE         12'h600
`define OFF_RR_LAST         12'h61C
`define RELOAD_MAGIC        32'h6E524635
`define RELOAD_VALUE_RESET  32'hFFFFFFFF
`define RELOAD_REGISTER_ENABLES_RESET          8'h01
`define PAUSE_CFG_RESET     2'h0
`define BIT_PAUSE_SLEEP     0
`define BIT_PAUSE_HALT      1
`define RESET_DELAY_TICKS   2'h2
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2
`endif

//--- wdt_pkg.sv
package wdt_pkg;
    typedef struct packed {
        logic sleeping;
        logic halted;
    } cpu_state_type;
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_RUN     = 3'b010,
        ST_EXPIRED = 3'b100
    } wdt_state_type;
endpackage

//--- lowfreq_countdown_watchdog.sv
`timescale 1ns/10ps
`default_nettype none
`include "wdt_consts.svh"
module lowfreq_countdown_watchdog
    import wdt_pkg::*;
#(
    parameter int NUM_RR = 8
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        lf_tick_pin,
    input  wire logic        cpu_sleeping_pin,
    input  wire logic        cpu_halted_pin,
    input  wire logic        other_lf_source_running,
    input  wire logic        start_trigger,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             irq,
    output logic             timeout_pulse,
    output logic             wdt_reset_req,
    output logic             force_rc_osc_on
);
    initial begin
        if (NUM_RR != 8) $error("NUM_RR must be 8");
    end

    logic [2:0]    tick_sync;
    cpu_state_type cpu_meta;
    cpu_state_type cpu_sync;
    wdt_state_type state;
    logic [31:0]   counter;
    logic [31:0]   reload_value;
    logic [7:0]    reload_register_enables;
    logic [1:0]    pause_cfg;
    logic [7:0]    rr_pending;
    logic          irq_enable;
    logic          timeout_flag;
    logic [1:0]    delay_cnt;
    logic [11:0]   aw_addr;
    logic [31:0]   w_data;
    logic          aw_held;
    logic          w_held;
    logic          lf_tick;
    logic          paused;
    logic          count_step;
    logic          wrap;
    logic          wr_fire;
    logic          wr_ok;
    logic          start_now;
    logic          cfg_open;
    logic          rr_hit;
    logic [2:0]    rr_idx;
    logic [7:0]    next_pending;
    logic          grant;
    logic          rd_ok;
    logic [31:0]   rd_word;
    logic [3:0]    s_axi_wstrb_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_sync <= 3'h0;
            cpu_meta  <= '0;
            cpu_sync  <= '0;
        end else begin
            tick_sync <= {tick_sync[1:0], lf_tick_pin};
            cpu_meta  <= {cpu_sleeping_pin, cpu_halted_pin};
            cpu_sync  <= cpu_meta;
        end
    end
    assign lf_tick = tick_sync[1] & ~tick_sync[2];

    // AXI write channel capture
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
    assign wr_ok         = wr_fire && (s_axi_wstrb_q == 4'hF);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 12'h000;
            w_data        <= 32'h0;
            s_axi_wstrb_q <= 4'h0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held        <= 1'b1;
                w_data        <= s_axi_wdata;
                s_axi_wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_map_ok(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    function automatic logic wr_map_ok(input logic [11:0] a);
        logic ok;
        ok = (a == `OFF_START_TASK) || (a == `OFF_START_LINK) || (a == `OFF_TIMEOUT_FLAG)
            || (a == `OFF_TIMEOUT_LINK) || (a == `OFF_IRQ_EN_SET) || (a == `OFF_IRQ_EN_CLR)
            || (a == `OFF_IRQ_STATUS) || (a == `OFF_RELOAD_VALUE) || (a == `OFF_RELOAD_REGISTER_ENABLES)
            || (a == `OFF_PAUSE_CFG)
            || (a >= `OFF_RR_BASE && a <= `OFF_RR_LAST && a[1:0] == 2'h0);
        return ok;
    endfunction

    assign start_now = (state == ST_IDLE) && (start_trigger
        || (wr_ok && aw_addr == `OFF_START_TASK && w_data[0]));
    assign cfg_open  = (state == ST_IDLE);
    assign rr_hit    = wr_ok && aw_addr >= `OFF_RR_BASE && aw_addr <= `OFF_RR_LAST;
    assign rr_idx    = aw_addr[4:2];

    // Configuration, locked once running
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reload_value <= `RELOAD_VALUE_RESET;
            reload_register_enables         <= `RELOAD_REGISTER_ENABLES_RESET;
            pause_cfg    <= `PAUSE_CFG_RESET;
        end else if (wr_ok && cfg_open && !start_now) begin
            if (aw_addr == `OFF_RELOAD_VALUE) reload_value <= w_data;
            if (aw_addr == `OFF_RELOAD_REGISTER_ENABLES) reload_register_enables <= w_data[7:0];
            if (aw_addr == `OFF_PAUSE_CFG) pause_cfg <= w_data[1:0];
        end
    end

    always_comb begin
        next_pending = rr_pending;
        if (rr_hit && w_data == `RELOAD_MAGIC) begin
            next_pending[rr_idx] = 1'b0;
        end
    end
    assign grant = (state == ST_RUN) && (rr_pending != 8'h0) && (next_pending == 8'h0);

    assign paused = (pause_cfg[`BIT_PAUSE_SLEEP] && cpu_sync.sleeping)
        || (pause_cfg[`BIT_PAUSE_HALT] && cpu_sync.halted);
    assign count_step = (state == ST_RUN) && lf_tick && !paused;
    // Wrap after reload plus one ticks
    assign wrap = count_step && (counter == 32'h0) && !grant;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state      <= ST_IDLE;
            counter    <= 32'h0;
            rr_pending <= 8'h0;
            delay_cnt  <= 2'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start_now) begin
                        state      <= ST_RUN;
                        counter    <= reload_value;
                        rr_pending <= reload_register_enables;
                    end
                end
                ST_RUN: begin
                    if (grant) begin
                        counter    <= reload_value;
                        rr_pending <= reload_register_enables;
                    end else if (wrap) begin
                        state     <= ST_EXPIRED;
                        delay_cnt <= irq_enable ? `RESET_DELAY_TICKS : 2'h0;
                    end else begin
                        rr_pending <= next_pending;
                        if (count_step) counter <= counter - 32'h1;
                    end
                end
                ST_EXPIRED: begin
                    if (lf_tick && delay_cnt != 2'h0) delay_cnt <= delay_cnt - 2'h1;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Timeout flag and interrupt enable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timeout_flag  <= 1'b0;
            irq_enable    <= 1'b0;
            timeout_pulse <= 1'b0;
        end else begin
            timeout_pulse <= wrap;
            if (wrap) begin
                timeout_flag <= 1'b1;
            end else if (wr_ok && (aw_addr == `OFF_TIMEOUT_FLAG) && !w_data[0]) begin
                timeout_flag <= 1'b0;
            end else if (wr_ok && (aw_addr == `OFF_IRQ_STATUS) && w_data[0]) begin
                timeout_flag <= 1'b0;
            end
            if (wr_ok && aw_addr == `OFF_IRQ_EN_SET && w_data[0]) irq_enable <= 1'b1;
            if (wr_ok && aw_addr == `OFF_IRQ_EN_CLR && w_data[0]) irq_enable <= 1'b0;
        end
    end

    assign irq = timeout_flag && irq_enable;
    assign wdt_reset_req = (state == ST_EXPIRED) && (delay_cnt == 2'h0);
    assign force_rc_osc_on = (state != ST_IDLE) && !other_lf_source_running;

    // AXI read channel
    always_comb begin
        rd_ok   = 1'b1;
        rd_word = 32'h0;
        case (s_axi_araddr)
            `OFF_TIMEOUT_FLAG: rd_word = {31'h0, timeout_flag};
            `OFF_IRQ_EN_SET:   rd_word = {31'h0, irq_enable};
            `OFF_IRQ_EN_CLR:   rd_word = {31'h0, irq_enable};
            `OFF_IRQ_STATUS:   rd_word = {31'h0, timeout_flag};
            `OFF_RUN_STATE:    rd_word = {31'h0, state == ST_RUN};
            `OFF_REQ_STATE:    rd_word = {24'h0, rr_pending & reload_register_enables};
            `OFF_RELOAD_VALUE: rd_word = reload_value;
            `OFF_RELOAD_REGISTER_ENABLES:         rd_word = {24'h0, reload_register_enables};
            `OFF_PAUSE_CFG:    rd_word = {30'h0, pause_cfg};
            `OFF_START_TASK, `OFF_START_LINK, `OFF_TIMEOUT_LINK: rd_word = 32'h0;
            default: rd_ok = (s_axi_araddr >= `OFF_RR_BASE && s_axi_araddr <= `OFF_RR_LAST);
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    a_start_loads: assert property (@(posedge aclk) disable iff (!aresetn)
        start_now |=> (state == ST_RUN) && (counter == $past(reload_value)))
        else $error("start did not load counter");
    a_grant_reload: assert property (@(posedge aclk) disable iff (!aresetn)
        grant |=> (counter == $past(reload_value)))
        else $error("grant did not reload");
    a_wrap_expire: assert property (@(posedge aclk) disable iff (!aresetn)
        wrap |=> (state == ST_EXPIRED) && timeout_flag && timeout_pulse)
        else $error("wrap did not expire");
    a_step_dec: assert property (@(posedge aclk) disable iff (!aresetn)
        (count_step && !grant && counter != 32'h0) |=> counter == $past(counter) - 32'h1)
        else $error("counter did not decrement");
    a_pause_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == ST_RUN && paused && !grant) |=> counter == $past(counter))
        else $error("counter moved while paused");
    a_cfg_lock: assert property (@(posedge aclk) disable iff (!aresetn)
        (state != ST_IDLE) |=> $stable(reload_value) && $stable(reload_register_enables) && $stable(pause_cfg))
        else $error("config changed while running");
    a_no_cancel: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == ST_EXPIRED) |=> (state == ST_EXPIRED))
        else $error("pending reset cancelled");
    a_fast_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        (wrap && !irq_enable) |=> wdt_reset_req)
        else $error("reset not raised");
    a_delay_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        (wrap && irq_enable) |=> !wdt_reset_req)
        else $error("reset not delayed");
    a_bad_magic: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == ST_RUN && rr_hit && w_data != `RELOAD_MAGIC && !wrap) |=>
        rr_pending == $past(rr_pending))
        else $error("bad magic changed pending");
    a_rc_force: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == ST_RUN && !other_lf_source_running) |-> force_rc_osc_on)
        else $error("oscillator not forced");

    c_start: cover property (@(posedge aclk) start_now);
    c_grant: cover property (@(posedge aclk) grant);
    c_timeout: cover property (@(posedge aclk) wrap && irq_enable);
    c_reset: cover property (@(posedge aclk) wdt_reset_req);
endmodule // lowfreq_countdown_watchdog
`default_nettype wire

//--- tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "wdt_consts.svh"
module tb;
    logic        aclk    = 1'b0;
    logic        aresetn = 1'b0;
    logic        lf      = 1'b0;
    logic        slp     = 1'b0;
    logic        hlt     = 1'b0;
    logic        oth     = 1'b0;
    logic        st      = 1'b0;
    logic [11:0] awaddr  = 12'h000;
    logic [11:0] araddr  = 12'h000;
    logic [31:0] wdata   = 32'h00000000;
    logic        awvalid = 1'b0;
    logic        wvalid  = 1'b0;
    logic        bready  = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready  = 1'b0;
    logic [31:0] rd;
    logic [1:0]  resp;
    wire logic        awready, wready, bvalid, arready, rvalid;
    wire logic        irq, to_p, rst_req, rc_on;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    int n_errors = 0;
    int cmp_count = 0;
    int n_to = 0;

    lowfreq_countdown_watchdog dut (.aclk(aclk), .aresetn(aresetn), .lf_tick_pin(lf),
        .cpu_sleeping_pin(slp), .cpu_halted_pin(hlt), .other_lf_source_running(oth),
        .start_trigger(st), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq),
        .timeout_pulse(to_p), .wdt_reset_req(rst_req), .force_rc_osc_on(rc_on));

    always #5 aclk = ~aclk;
    // Count pulses where they are settled
    always @(negedge aclk) if (to_p === 1'b1) n_to <= n_to + 1;

    task automatic give_verdict();
        if (n_errors == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic aw, w, aw_hit, w_hit, b_hit;
        aw = 1'b1;
        w = 1'b1;
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (int t = 0; t < 50; t++) begin
            // Handshakes judged on values that stand at the coming edge
            @(negedge aclk);
            aw_hit = aw && awready === 1'b1;
            w_hit = w && wready === 1'b1;
            b_hit = bvalid === 1'b1;
            if (b_hit) resp = bresp;
            @(posedge aclk);
            if (aw_hit) begin awvalid <= 1'b0; aw = 1'b0; end
            if (w_hit) begin wvalid <= 1'b0; w = 1'b0; end
            if (b_hit) begin bready <= 1'b0; @(posedge aclk); return; end
        end
        chk(32'h1, 32'h0);
    endtask

    task automatic rdr(input logic [11:0] a);
        logic ar, ar_hit, r_hit;
        ar = 1'b1;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (int t = 0; t < 50; t++) begin
            @(negedge aclk);
            ar_hit = ar && arready === 1'b1;
            r_hit = rvalid === 1'b1;
            if (r_hit) begin rd = rdata; resp = rresp; end
            @(posedge aclk);
            if (ar_hit) begin arvalid <= 1'b0; ar = 1'b0; end
            if (r_hit) begin rready <= 1'b0; @(posedge aclk); return; end
        end
        chk(32'h1, 32'h0);
    endtask

    // One low-frequency rising edge per pass
    task automatic tick(input int n);
        repeat (n) begin
            lf <= 1'b1;
            repeat (8) @(posedge aclk);
            lf <= 1'b0;
            repeat (8) @(posedge aclk);
        end
    endtask

    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask

    task automatic t_regs();
        rdr(`OFF_RELOAD_VALUE); chk(rd, `RELOAD_VALUE_RESET);
        rdr(`OFF_RELOAD_REGISTER_ENABLES); chk(rd, {24'h000000, `RELOAD_REGISTER_ENABLES_RESET});
        rdr(`OFF_PAUSE_CFG); chk(rd, 32'h00000000);
        rdr(`OFF_RUN_STATE); chk(rd, 32'h00000000);
        rdr(12'h7F0); chk({30'h0, resp}, {30'h0, `RESP_SLVERR});
    endtask

    task automatic t_period();
        int b;
        b = n_to;
        oth <= 1'b0;
        wr(`OFF_RELOAD_VALUE, 32'h00000003);
        tick(2); chk(n_to, b);
        wr(`OFF_START_TASK, 32'h00000001);
        rdr(`OFF_RUN_STATE); chk(rd, 32'h00000001);
        chk(rc_on, 1'b1);
        oth <= 1'b1;
        @(posedge aclk);
        @(posedge aclk); chk(rc_on, 1'b0);
        wr(`OFF_RELOAD_VALUE, 32'h00000009);
        rdr(`OFF_RELOAD_VALUE); chk(rd, 32'h00000003);
        tick(3); chk(n_to, b);
        chk(rst_req, 1'b0);
        tick(1); chk(n_to, b + 1);
        chk(rst_req, 1'b1);
        do_reset();
        chk(rst_req, 1'b0);
    endtask

    task automatic t_reload();
        int b;
        b = n_to;
        wr(`OFF_RELOAD_REGISTER_ENABLES, 32'h00000003);
        wr(`OFF_RELOAD_VALUE, 32'h00000002);
        wr(`OFF_START_TASK, 32'h00000001);
        tick(2);
        wr(`OFF_RR_BASE, `RELOAD_MAGIC);
        rdr(`OFF_REQ_STATE); chk(rd, 32'h00000002);
        wr(`OFF_RR_BASE + 12'h004, 32'h12345678);
        rdr(`OFF_REQ_STATE); chk(rd, 32'h00000002);
        wr(`OFF_RR_BASE + 12'h004, `RELOAD_MAGIC);
        rdr(`OFF_REQ_STATE); chk(rd, 32'h00000003);
        tick(2); chk(n_to, b);
        tick(1); chk(n_to, b + 1);
        do_reset();
    endtask

    task automatic t_irq();
        int b;
        b = n_to;
        wr(`OFF_IRQ_EN_SET, 32'h00000001);
        wr(`OFF_RELOAD_VALUE, 32'h00000000);
        wr(`OFF_START_TASK, 32'h00000001);
        tick(1); chk(n_to, b + 1);
        chk(irq, 1'b1);
        chk(rst_req, 1'b0);
        wr(`OFF_IRQ_EN_CLR, 32'h00000001);
        @(posedge aclk); chk(irq, 1'b0);
        wr(`OFF_IRQ_EN_SET, 32'h00000001);
        @(posedge aclk); chk(irq, 1'b1);
        wr(`OFF_IRQ_STATUS, 32'h00000001);
        @(posedge aclk); chk(irq, 1'b0);
        tick(1); chk(rst_req, 1'b0);
        tick(1); chk(rst_req, 1'b1);
        do_reset();
    endtask

    task automatic t_pause();
        int b;
        b = n_to;
        wr(`OFF_PAUSE_CFG, 32'h00000002);
        wr(`OFF_RELOAD_VALUE, 32'h00000001);
        st <= 1'b1;
        @(posedge aclk);
        st <= 1'b0;
        hlt <= 1'b1;
        repeat (4) @(posedge aclk);
        tick(3); chk(n_to, b);
        hlt <= 1'b0;
        slp <= 1'b1;
        repeat (4) @(posedge aclk);
        tick(2); chk(n_to, b + 1);
        slp <= 1'b0;
        do_reset();
    endtask

    initial begin
        #300000;
        n_errors++;
        give_verdict();
    end

    initial begin
        do_reset();
        t_regs();
        t_period();
        t_reload();
        t_irq();
        t_pause();
        give_verdict();
    end
endmodule // tb
`default_nettype wire
